// File: rtl/ifsc_top.v
// interrupt flag register, system control register two, sleep decode
// assumes avalon-mm master on mclk_i, irq pins synchronous to mclk_i
//
// How it works
// R01: sleep with direct transition enable sets flag
// R02: write 0 clears direct flag, else held
// R03: selected edge on pin three sets flag
// R04: write 0 clears pin three flag
// R05: selected edge on pin zero sets flag
// R06: write 0 clears pin zero flag
// R07: flag bits 5,4 read 1; 6,2,1 read 0
// R08: sleep mode select with standby picks mode
// R09: direct enable also steers mode choice
// R10: clock select 0XX undivided, else /8../64
// R11: new divider applies only after sleep
// R12: unused bits read 0, all reset 0
// R13: writing 1 leaves flags unchanged
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ifsc_defines.vh"
module ifsc_top (
  input wire mclk_i,
  input wire srst_i,
  input wire [`IFSC_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire sleep_exec_i,
  input wire ext_irq_pin_three_i,
  input wire ext_irq_pin_zero_i,
  output reg irq_o,
  output reg sleep_req_o,
  output reg [2:0] sleep_mode_o,
  output reg op_clk_en_o,
  output reg [2:0] op_clk_sel_o
);
  // sleep mode codes presented to the power-down sequencer
  localparam MODE_SLEEP = 3'h0;
  localparam MODE_STANDBY = 3'h1;
  localparam MODE_SUBSLEEP = 3'h2;
  localparam MODE_DIRECT = 3'h3;
  localparam MODE_DIRECT_STBY = 3'h4;

  localparam ST_IDLE = 2'h0;
  localparam ST_ANSWER = 2'h1;

  reg [1:0] state_reg;
  reg [7:0] flag_reg;
  reg [7:0] sys_ctrl_two_reg;
  reg [7:0] ctrl_reg;
  reg [`IFSC_EVT_W-1:0] stat_reg;
  reg [`IFSC_EVT_W-1:0] mask_reg;
  reg pin3_d_reg;
  reg pin0_d_reg;
  wire [2:0] div_sel;
  wire div_en;
  reg [31:0] rdata;

  // writes land on the answering edge, the one where the master sees waitrequest low
  wire wr_fire = (state_reg == ST_ANSWER) && avs_write_i && avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];
  wire wr_flag = wr_fire && (avs_address_i == `IFSC_OFF_FLAG);
  wire wr_sc2 = wr_fire && (avs_address_i == `IFSC_OFF_SCR_TWO);
  wire wr_stat = wr_fire && (avs_address_i == `IFSC_OFF_IRQ_STAT);
  wire wr_mask = wr_fire && (avs_address_i == `IFSC_OFF_IRQ_MASK);
  wire wr_ctrl = wr_fire && (avs_address_i == `IFSC_OFF_CTRL);

  function edge_hit;
    input rise;
    input cur;
    input prev;
    begin
      edge_hit = rise ? (cur & ~prev) : (~cur & prev);
    end
  endfunction

  wire direct_en = sys_ctrl_two_reg[`IFSC_SC2_DIRECT_EN];
  wire sleep_sel = sys_ctrl_two_reg[`IFSC_SC2_SLEEP_SEL];
  wire standby_sel = ctrl_reg[`IFSC_CTRL_STANDBY];
  wire set_dt = sleep_exec_i && direct_en; // R01
  wire set_i3 = ctrl_reg[`IFSC_CTRL_EN3] &&
    edge_hit(ctrl_reg[`IFSC_CTRL_RISE3], ext_irq_pin_three_i, pin3_d_reg); // R03
  wire set_i0 = ctrl_reg[`IFSC_CTRL_EN0] &&
    edge_hit(ctrl_reg[`IFSC_CTRL_RISE0], ext_irq_pin_zero_i, pin0_d_reg); // R05

  // mode chosen from select, direct enable and standby
  reg [2:0] mode_next;
  always @* begin
    case ({standby_sel, sleep_sel, direct_en})
      3'b000: mode_next = MODE_SLEEP; // R08
      3'b010: mode_next = MODE_SUBSLEEP; // R08
      3'b100: mode_next = MODE_STANDBY; // R08
      3'b110: mode_next = MODE_STANDBY;
      3'b001: mode_next = MODE_DIRECT; // R09
      3'b011: mode_next = MODE_DIRECT;
      3'b101: mode_next = MODE_DIRECT_STBY; // R09
      3'b111: mode_next = MODE_DIRECT_STBY;
      default: mode_next = MODE_SLEEP;
    endcase
  end

  // divider reloads only on sleep, so a write alone changes nothing
  ifsc_clk_div u_div (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .load_i(sleep_exec_i), // R11
    .sel_i(sys_ctrl_two_reg[`IFSC_SC2_MA_HI:`IFSC_SC2_MA_LO]), // R10
    .clk_en_o(div_en),
    .sel_o(div_sel)
  );

  always @* begin
    rdata = 32'h0000_0000;
    case (avs_address_i)
      `IFSC_OFF_FLAG: rdata[7:0] = flag_reg | `IFSC_FLAG_ONES; // R07
      `IFSC_OFF_SCR_TWO: rdata[7:0] = sys_ctrl_two_reg & `IFSC_SC2_WMASK; // R12
      `IFSC_OFF_IRQ_STAT: rdata[`IFSC_EVT_W-1:0] = stat_reg;
      `IFSC_OFF_IRQ_MASK: rdata[`IFSC_EVT_W-1:0] = mask_reg;
      `IFSC_OFF_CTRL: rdata[7:0] = ctrl_reg;
      `IFSC_OFF_CLKSTAT: rdata[2:0] = div_sel;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // one wait cycle per access: request taken in idle, answered next edge
  always @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            state_reg <= ST_ANSWER;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= rdata;
          end
        end
        ST_ANSWER: begin
          state_reg <= ST_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          state_reg <= ST_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      flag_reg <= `IFSC_FLAG_RST; // R12
      sys_ctrl_two_reg <= `IFSC_SC2_RST; // R12
      ctrl_reg <= `IFSC_CTRL_RST;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      pin3_d_reg <= 1'b1;
      pin0_d_reg <= 1'b1;
      irq_o <= 1'b0;
      sleep_req_o <= 1'b0;
      sleep_mode_o <= MODE_SLEEP;
      op_clk_en_o <= 1'b0;
      op_clk_sel_o <= 3'h0;
    end else begin
      pin3_d_reg <= ext_irq_pin_three_i;
      pin0_d_reg <= ext_irq_pin_zero_i;
      // set wins over a clearing write in the same cycle
      if (set_dt)
        flag_reg[`IFSC_FLAG_DT] <= 1'b1; // R01
      else if (wr_flag && !wd[`IFSC_FLAG_DT])
        flag_reg[`IFSC_FLAG_DT] <= 1'b0; // R02 R13
      if (set_i3)
        flag_reg[`IFSC_FLAG_I3] <= 1'b1; // R03
      else if (wr_flag && !wd[`IFSC_FLAG_I3])
        flag_reg[`IFSC_FLAG_I3] <= 1'b0; // R04 R13
      if (set_i0)
        flag_reg[`IFSC_FLAG_I0] <= 1'b1; // R05
      else if (wr_flag && !wd[`IFSC_FLAG_I0])
        flag_reg[`IFSC_FLAG_I0] <= 1'b0; // R06 R13
      if (wr_sc2)
        sys_ctrl_two_reg <= wd & `IFSC_SC2_WMASK; // R12
      if (wr_ctrl)
        ctrl_reg <= wd & 8'h1F;
      if (wr_mask)
        mask_reg <= wd[`IFSC_EVT_W-1:0];
      stat_reg <= (stat_reg & ~(wr_stat ? wd[`IFSC_EVT_W-1:0] : 3'h0)) |
        {set_i0, set_i3, set_dt};
      irq_o <= |(stat_reg & mask_reg);
      sleep_req_o <= sleep_exec_i;
      if (sleep_exec_i)
        sleep_mode_o <= mode_next; // R08 R09
      op_clk_en_o <= div_sel[2] ? div_en : 1'b1; // R10
      op_clk_sel_o <= div_sel;
    end
  end
endmodule // ifsc_top

// File: rtl/ifsc_defines.vh
// register offsets, field positions, reset values and divider counter width
// for the interrupt flag / sleep clock control block
`ifndef IFSC_DEFINES_VH
`define IFSC_DEFINES_VH

`define IFSC_ADDR_W 4
`define IFSC_OFF_FLAG 4'h0
`define IFSC_OFF_SCR_TWO 4'h1
`define IFSC_OFF_IRQ_STAT 4'h2
`define IFSC_OFF_IRQ_MASK 4'h3
`define IFSC_OFF_CTRL 4'h4
`define IFSC_OFF_CLKSTAT 4'h5

`define IFSC_FLAG_DT 7
`define IFSC_FLAG_I3 3
`define IFSC_FLAG_I0 0
`define IFSC_FLAG_ONES 8'h30
`define IFSC_FLAG_RST 8'h00

`define IFSC_SC2_SLEEP_SEL 7
`define IFSC_SC2_DIRECT_EN 5
`define IFSC_SC2_MA_HI 4
`define IFSC_SC2_MA_LO 2
`define IFSC_SC2_WMASK 8'hBC
`define IFSC_SC2_RST 8'h00

`define IFSC_CTRL_STANDBY 0
`define IFSC_CTRL_EN3 1
`define IFSC_CTRL_EN0 2
`define IFSC_CTRL_RISE3 3
`define IFSC_CTRL_RISE0 4
`define IFSC_CTRL_RST 8'h00

`define IFSC_EVT_DT 0
`define IFSC_EVT_I3 1
`define IFSC_EVT_I0 2
`define IFSC_EVT_W 3

`define IFSC_DIV_W 6

`endif

// File: rtl/ifsc_clk_div.v
// clock enable divider for the active-mode operating clock
// assumes one system clock; the division setting changes only on load_i
`timescale 1ns/1ps
`include "ifsc_defines.vh"
module ifsc_clk_div (
  input wire mclk_i,
  input wire srst_i,
  input wire load_i,
  input wire [2:0] sel_i,
  output reg clk_en_o,
  output reg [2:0] sel_o
);
  reg [`IFSC_DIV_W-1:0] cnt_reg;
  reg [`IFSC_DIV_W-1:0] top_reg;

  function [`IFSC_DIV_W-1:0] div_top;
    input [2:0] sel;
    begin
      case (sel)
        3'h4: div_top = 6'h07;
        3'h5: div_top = 6'h0F;
        3'h6: div_top = 6'h1F;
        3'h7: div_top = 6'h3F;
        default: div_top = 6'h00;
      endcase
    end
  endfunction

  always @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_reg <= 6'h00;
      top_reg <= 6'h00;
      sel_o <= 3'h0;
      clk_en_o <= 1'b0;
    end else begin
      if (load_i) begin
        // restart the count so the first new period is whole
        top_reg <= div_top(sel_i);
        sel_o <= sel_i;
        cnt_reg <= 6'h00;
        clk_en_o <= 1'b0;
      end else if (cnt_reg == top_reg) begin
        cnt_reg <= 6'h00;
        clk_en_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
        clk_en_o <= 1'b0;
      end
    end
  end
endmodule // ifsc_clk_div

// File: testbench/ifsc_core_mdl.sv
// core and pin model: sleep pulse and two irq pin levels
// assumes the bench calls its tasks; pins idle high
`timescale 1ns/1ps
module ifsc_core_mdl (
  input wire mclk_i,
  output reg sleep_exec_o,
  output reg pin_three_o,
  output reg pin_zero_o
);
  initial begin
    sleep_exec_o = 1'b0;
    pin_three_o = 1'b1;
    pin_zero_o = 1'b1;
  end
  task do_sleep;
    begin
      @(posedge mclk_i);
      sleep_exec_o <= 1'b1;
      @(posedge mclk_i);
      sleep_exec_o <= 1'b0;
    end
  endtask
  task pin(input sel, input lvl);
    begin
      @(posedge mclk_i);
      if (sel) pin_three_o <= lvl;
      else pin_zero_o <= lvl;
    end
  endtask
endmodule // ifsc_core_mdl

// File: testbench/ifsc_top_sva.sv
// port checker for ifsc_top
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module ifsc_top_sva (
  input wire mclk_i, srst_i, avs_read_i, avs_write_i, avs_waitrequest_o,
  input wire sleep_exec_i, sleep_req_o, op_clk_en_o,
  input wire [3:0] avs_address_i,
  input wire [31:0] avs_readdata_o,
  input wire [2:0] sleep_mode_o, op_clk_sel_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_sleep_pulse: assert property (sleep_req_o == $past(sleep_exec_i))
    else $error("sleep request not one cycle after sleep");
  a_mode_range: assert property (sleep_mode_o <= 3'h4)
    else $error("sleep mode code out of range");
  a_mode_hold: assert property (!$past(sleep_exec_i) |-> $stable(sleep_mode_o))
    else $error("sleep mode changed without sleep");
  a_sel_hold: assert property (!$past(sleep_exec_i, 2) |-> $stable(op_clk_sel_o))
    else $error("divider changed without sleep");
  a_clk_undiv: assert property (!op_clk_sel_o[2] && $stable(op_clk_sel_o) && !$past(srst_i)
    |-> op_clk_en_o)
    else $error("undivided clock enable dropped");
  a_flag_fixed: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 4'h0
    |=> avs_readdata_o[6:4] == 3'h3 && avs_readdata_o[2:1] == 2'h0)
    else $error("flag register fixed bits wrong");
  a_sc2_unused: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 4'h1
    |=> !avs_readdata_o[6] && avs_readdata_o[1:0] == 2'h0)
    else $error("control register unused bits set");
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer not after one cycle");
  a_ack_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer longer than one cycle");
endmodule // ifsc_top_sva
bind ifsc_top ifsc_top_sva u_sva (.*);

// File: testbench/tb.sv
// bench for ifsc_top: bus tasks, flag, interrupt and divider tests
// assumes the core model drives sleep and pins
`timescale 1ns/1ps
module tb;
  reg mclk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [3:0] avs_address_i = 4'h0;
  reg avs_read_i = 1'b0;
  reg avs_write_i = 1'b0;
  reg [31:0] avs_writedata_i = 32'h0;
  reg [3:0] avs_byteenable_i = 4'hF;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, irq_o, sleep_req_o, op_clk_en_o;
  wire sleep_exec_i, ext_irq_pin_three_i, ext_irq_pin_zero_i;
  wire [2:0] sleep_mode_o, op_clk_sel_o;
  integer bad_count = 0, checks = 0, n, k;
  reg [31:0] q;
  always #20 mclk_i = ~mclk_i;
  ifsc_core_mdl u_core (.mclk_i(mclk_i), .sleep_exec_o(sleep_exec_i),
    .pin_three_o(ext_irq_pin_three_i), .pin_zero_o(ext_irq_pin_zero_i));
  ifsc_top dut (.*);
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // holds the request until waitrequest is seen low, then drops it
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_read_i <= !w;
      avs_write_i <= w;
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
    end
  endtask
  task wait_en;
    begin
      n = 0;
      do begin
        @(posedge mclk_i);
        n = n + 1;
      end while (op_clk_en_o !== 1'b1 && n < 200);
    end
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'h30);
    bus(1, 4'h1, 8'hFF); bus(0, 4'h1, 8'h00); cmp8(q[7:0], 8'hBC);
    u_core.do_sleep;
    bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'hB0);
    bus(1, 4'h0, 8'hFF); bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'hB0);
    bus(1, 4'h0, 8'h7F); bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'h30);
    $display("test direct flag done");
    bus(1, 4'h3, 8'h07); bus(1, 4'h2, 8'h07); bus(1, 4'h4, 8'h16);
    u_core.pin(1, 0); u_core.pin(0, 0); u_core.pin(0, 1); u_core.pin(1, 1);
    bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'h39);
    cmp8({7'h0, irq_o}, 8'h01);
    bus(1, 4'h0, 8'hF7); bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'h31);
    bus(1, 4'h0, 8'hFE); bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'h30);
    bus(0, 4'h2, 8'h00); cmp8(q[7:0], 8'h06);
    bus(1, 4'h3, 8'h00); bus(0, 4'h6, 8'h00); cmp8(q[7:0], 8'h00);
    cmp8({7'h0, irq_o}, 8'h00);
    bus(1, 4'h2, 8'h07); bus(1, 4'h4, 8'h00); u_core.pin(1, 0); u_core.pin(1, 1);
    bus(0, 4'h0, 8'h00); cmp8(q[7:0], 8'h30);
    $display("test pin flags done");
    for (k = 3; k < 8; k = k + 1) begin
      bus(1, 4'h1, {3'h0, k[2:0], 2'h0});
      bus(0, 4'h5, 8'h00); cmp8(q[7:0], {5'h0, (k == 3) ? 3'h7 : k[2:0] - 3'h1});
      u_core.do_sleep;
      // skip the edge that still shows a pulse of the old setting
      @(posedge mclk_i);
      wait_en;
      wait_en;
      cmp8(n[7:0], (k < 4) ? 8'h01 : (8'h08 << (k - 4)));
      cmp8({5'h0, op_clk_sel_o}, {5'h0, k[2:0]});
    end
    $display("test divider done");
    cmp8({5'h0, sleep_mode_o}, 8'h00);
    bus(1, 4'h1, 8'h80); u_core.do_sleep; @(posedge mclk_i);
    cmp8({5'h0, sleep_mode_o}, 8'h02);
    bus(1, 4'h4, 8'h01); u_core.do_sleep; @(posedge mclk_i);
    cmp8({5'h0, sleep_mode_o}, 8'h01);
    bus(1, 4'h1, 8'h20); u_core.do_sleep; @(posedge mclk_i);
    cmp8({5'h0, sleep_mode_o}, 8'h04);
    bus(1, 4'h4, 8'h00); u_core.do_sleep; @(posedge mclk_i);
    cmp8({5'h0, sleep_mode_o}, 8'h03);
    $display("test sleep mode done");
    close_out;
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    bad_count = bad_count + 1;
    close_out;
  end
endmodule // tb
